// file: inc/sfr_pkg.sv
/*
 * Constants and types shared by the serial flash read front end.
 * Assumes a byte wide array behind the block, read combinationally.
 */
package sfr_pkg;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_READ     = 8'h03;
    localparam logic [7:0] OP_READ_4B  = 8'h13;
    localparam logic [7:0] OP_QUICK    = 8'h0B;
    localparam logic [7:0] OP_QUICK_4B = 8'h0C;
    localparam logic [7:0] OP_DUAL     = 8'h3B;
    localparam logic [7:0] OP_DUAL_4B  = 8'h3C;
    localparam logic [7:0] OP_QUAD     = 8'h6B;
    localparam logic [7:0] OP_QUAD_4B  = 8'h6C;
    localparam logic [7:0] OP_QIO      = 8'hEB;
    localparam logic [7:0] OP_QIO_4B   = 8'hEC;
    localparam logic [7:0] OP_QIO_DDR  = 8'hED;
    localparam logic [7:0] OP_QIO_DDR4 = 8'hEE;

    // ************************************************************
    // Field widths and counts
    // ************************************************************
    localparam int         ARR_AW      = 23;
    localparam int         BYTE_W      = 8;
    localparam int         FIFO_DEPTH  = 8;
    localparam logic [2:0] LANE_1      = 3'h1;
    localparam logic [2:0] LANE_2      = 3'h2;
    localparam logic [2:0] LANE_4      = 3'h4;
    localparam logic [5:0] OPC_BITS    = 6'h08;
    localparam logic [5:0] ADDR_BITS_3 = 6'h18;
    localparam logic [5:0] ADDR_BITS_4 = 6'h20;
    localparam logic [5:0] MODE_BITS   = 6'h08;
    localparam logic [3:0] MODE_CONT   = 4'hA;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] PAT_CYCLES  = 4'h4;
    localparam logic [2:0] PAT_FIRST   = 3'h7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } sfr_state_t;

    typedef struct packed {
        logic       ok;
        logic       a4;
        logic       ddr;
        logic       has_mode;
        logic       has_dummy;
        logic [2:0] aw;
        logic [2:0] ow;
    } sfr_cmd_t;

endpackage

// file: inc/sfr_fifo_if.sv
/*
 * Handshake bundle between the read front end and its byte FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface sfr_fifo_if #(
    parameter int WIDTH = 8
);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;
    logic             flush;

    modport fifo (
        input  in_valid, in_data, out_ready, flush,
        output in_ready, out_valid, out_data
    );
    modport user (
        output in_valid, in_data, out_ready, flush,
        input  in_ready, out_valid, out_data
    );
endinterface

// file: hdl/sfr_fifo.sv
/*
 * Synchronous FIFO with flush, valid/ready on both sides.
 * Assumes WIDTH matches the interface width.
 */
`timescale 1ns/1ps
module sfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,     // Block clock
    input wire logic rst,     // Async reset, high
    sfr_fifo_if.fifo port_if  // Fill and drain side
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_q;
    logic [PW:0]      wr_d;
    logic [PW:0]      rd_q;
    logic [PW:0]      rd_d;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign full  = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
    assign empty = (wr_q == rd_q);
    assign push  = port_if.in_valid && !full && !port_if.flush;
    assign pop   = port_if.out_ready && !empty && !port_if.flush;

    assign port_if.in_ready  = !full;
    assign port_if.out_valid = !empty;
    assign port_if.out_data  = mem[rd_q[PW-1:0]];

    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (port_if.flush) begin
            wr_d = '0;
            rd_d = '0;
        end else begin
            if (push) begin
                wr_d = wr_q + 1'b1;
            end
            if (pop) begin
                rd_d = rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[PW-1:0]] <= port_if.in_data;
        end
    end
endmodule

// file: hdl/sfr_read_front.sv
/*
 * Serial flash array read front end: decodes read commands from the
 * host, fetches array bytes through a FIFO and shifts them out.
 * Assumes sck, cs_n and io_i are asynchronous pins, sck much slower
 * than clk, and an array that answers rd_addr within the same cycle.
 */
// What this block does
// - Opcode one bit per rising edge, four in quad-peripheral
// - SDR samples rising; DDR uses both edges
// - 03h length per setting, 13h four bytes
// - 0Bh/0Ch addresses then latency dummy cycles
// - 3Bh/3Ch addresses then dummy, two lanes (four in quad-peripheral)
// - 6Bh/6Ch addresses then dummy, four lanes
// - Single-width data leaves on IO1
// - Dual output two bits per falling edge
// - Quad output nibble per falling edge
// - Address increments per byte, wraps to zero
// - Address bits above A22 ignored
// - Dummy count comes from latency code
// - Host values during dummy ignored
// - Dummy counted falling to falling edge
// - Zero latency: data on next falling edge
// - DDR learning pattern in final eight edges
// - Chip select high ends the read
// - Mode bits allow instruction-free next read
// - Continuous only when upper mode nibble A
`timescale 1ns/1ps
module sfr_read_front
    import sfr_pkg::*;
(
    input  wire logic              clk,                  // Block clock
    input  wire logic              rst,                  // Async reset, high
    input  wire logic              sck,                  // Host serial clock
    input  wire logic              cs_n,                 // Host chip select
    input  wire logic [3:0]        io_i,                 // IO pins in
    output logic      [3:0]        io_o,                 // IO pins out
    output logic      [3:0]        io_oe,                // IO drive enables
    input  wire logic              addr_len_4b,          // Four-byte address mode
    input  wire logic [3:0]        latency_code,         // Dummy cycle count
    input  wire logic              learning_pattern_en,  // DDR pattern enable
    input  wire logic [7:0]        learning_pattern,     // DDR pattern value
    input  wire logic              quad_peripheral_mode, // Four-lane opcodes
    output logic      [ARR_AW-1:0] rd_addr,              // Array read address
    input  wire logic [7:0]        rd_data,              // Array byte at rd_addr
    output logic                   rd_en,                // Byte taken this cycle
    output logic                   busy,                 // Frame in progress
    output logic                   cont_mode             // Continuous read armed
);

    // ************************************************************
    // Pin synchronisers and edge finding
    // ************************************************************
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic       sck_h_q;
    logic       cs_h_q;
    logic       sck_s;
    logic       cs_s;
    logic [3:0] io_s;
    logic       rise;
    logic       fall;
    logic       cs_fall;
    logic       cs_rise;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 6'h30;
            sync2_q <= 6'h30;
            sck_h_q <= 1'b1;
            cs_h_q  <= 1'b1;
        end else begin
            sync1_q <= {sck, cs_n, io_i};
            sync2_q <= sync1_q;
            sck_h_q <= sync2_q[5];
            cs_h_q  <= sync2_q[4];
        end
    end

    assign sck_s   = sync2_q[5];
    assign cs_s    = sync2_q[4];
    assign io_s    = sync2_q[3:0];
    assign rise    = sck_s && !sck_h_q;
    assign fall    = !sck_s && sck_h_q;
    assign cs_fall = !cs_s && cs_h_q;
    assign cs_rise = cs_s && !cs_h_q;

    // ************************************************************
    // Byte FIFO
    // ************************************************************
    sfr_fifo_if #(.WIDTH(BYTE_W)) buf_if ();

    sfr_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_buf (
        .clk     (clk),
        .rst     (rst),
        .port_if (buf_if.fifo)
    );

    // ************************************************************
    // Opcode decode
    // ************************************************************
    function automatic sfr_cmd_t decode(input logic [7:0] op, input logic qpm,
                                        input logic alen);
        sfr_cmd_t c;
        c = '{ok: 1'b1, a4: alen, ddr: 1'b0, has_mode: 1'b0, has_dummy: 1'b0,
              aw: LANE_1, ow: LANE_1};
        unique case (op)
            OP_READ:     c.a4 = alen;
            OP_READ_4B:  c.a4 = 1'b1;
            OP_QUICK:    c.has_dummy = 1'b1;
            OP_QUICK_4B: begin
                c.a4 = 1'b1;
                c.has_dummy = 1'b1;
            end
            OP_DUAL, OP_DUAL_4B: begin
                c.a4 = (op == OP_DUAL_4B) ? 1'b1 : alen;
                c.has_dummy = 1'b1;
                c.ow = LANE_2;
            end
            OP_QUAD, OP_QUAD_4B: begin
                c.a4 = (op == OP_QUAD_4B) ? 1'b1 : alen;
                c.has_dummy = 1'b1;
                c.ow = LANE_4;
            end
            OP_QIO, OP_QIO_4B, OP_QIO_DDR, OP_QIO_DDR4: begin
                c.a4 = (op == OP_QIO_4B || op == OP_QIO_DDR4) ? 1'b1 : alen;
                c.ddr = (op == OP_QIO_DDR || op == OP_QIO_DDR4);
                c.has_mode = 1'b1;
                c.has_dummy = 1'b1;
                c.aw = LANE_4;
                c.ow = LANE_4;
            end
            default:     c.ok = 1'b0;
        endcase
        if (qpm) begin
            c.aw = LANE_4;
            c.ow = LANE_4;
        end
        return c;
    endfunction

    // ************************************************************
    // Command sequencer
    // ************************************************************
    sfr_state_t        state_q, state_d;
    sfr_cmd_t          cmd_q, cmd_d;
    sfr_cmd_t          cont_cmd_q, cont_cmd_d;
    logic [31:0]       sh_q, sh_d;
    logic [5:0]        cnt_q, cnt_d;
    logic [7:0]        mode_q, mode_d;
    logic              mode_done_q, mode_done_d;
    logic              cont_q, cont_d;
    logic [3:0]        dcnt_q, dcnt_d;
    logic [2:0]        pat_idx_q, pat_idx_d;
    logic [7:0]        obyte_q, obyte_d;
    logic [3:0]        ocnt_q, ocnt_d;
    logic [3:0]        io_o_q, io_o_d;
    logic [3:0]        io_oe_q, io_oe_d;
    logic              fetch_on_q, fetch_on_d;
    logic [ARR_AW-1:0] fetch_addr_q, fetch_addr_d;
    logic              flush;
    logic              pop;

    always_comb begin
        logic [31:0] sh_n;
        logic [5:0]  cnt_n;
        logic [5:0]  need;
        logic        samp;
        logic        emit;
        logic        start_dummy;
        logic [7:0]  cur;
        sh_n = sh_q;
        cnt_n = cnt_q;
        need = cmd_q.a4 ? ADDR_BITS_4 : ADDR_BITS_3;
        samp = rise || (cmd_q.ddr && fall);
        emit = 1'b0;
        start_dummy = 1'b0;
        cur = (ocnt_q == 4'h0) ? buf_if.out_data : obyte_q;
        state_d = state_q;
        cmd_d = cmd_q;
        cont_cmd_d = cont_cmd_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        mode_d = mode_q;
        mode_done_d = mode_done_q;
        cont_d = cont_q;
        dcnt_d = dcnt_q;
        pat_idx_d = pat_idx_q;
        obyte_d = obyte_q;
        ocnt_d = ocnt_q;
        io_o_d = io_o_q;
        io_oe_d = io_oe_q;
        fetch_on_d = fetch_on_q;
        fetch_addr_d = fetch_addr_q;
        flush = 1'b0;
        pop = 1'b0;
        if (fetch_on_q && buf_if.in_ready) begin
            fetch_addr_d = fetch_addr_q + 1'b1;
        end
        if (cs_rise) begin
            state_d = ST_IDLE;
            io_oe_d = 4'h0;
            fetch_on_d = 1'b0;
            flush = 1'b1;
            cont_d = mode_done_q && (mode_q[7:4] == MODE_CONT);
            cont_cmd_d = cmd_q;
        end else if (cs_fall) begin
            state_d = cont_q ? ST_ADDR : ST_CMD;
            cmd_d = cont_cmd_q;
            sh_d = '0;
            cnt_d = '0;
            mode_done_d = 1'b0;
            ocnt_d = '0;
        end else begin
            if (state_q != ST_CMD) begin
                sh_n = (cmd_q.aw == LANE_4) ? {sh_q[27:0], io_s} : {sh_q[30:0], io_s[0]};
            end else begin
                sh_n = quad_peripheral_mode ? {sh_q[27:0], io_s} : {sh_q[30:0], io_s[0]};
            end
            unique case (state_q)
                ST_IDLE, ST_IGNORE: begin
                end
                ST_CMD: begin
                    if (rise) begin
                        cnt_n = cnt_q + (quad_peripheral_mode ? 6'(LANE_4) : 6'(LANE_1));
                        sh_d = sh_n;
                        cnt_d = cnt_n;
                        if (cnt_n == OPC_BITS) begin
                            cmd_d = decode(sh_n[7:0], quad_peripheral_mode, addr_len_4b);
                            state_d = cmd_d.ok ? ST_ADDR : ST_IGNORE;
                            cnt_d = '0;
                        end
                    end
                end
                ST_ADDR: begin
                    if (samp) begin
                        cnt_n = cnt_q + 6'(cmd_q.aw);
                        sh_d = sh_n;
                        cnt_d = cnt_n;
                        if (cnt_n == need) begin
                            fetch_addr_d = sh_n[ARR_AW-1:0];
                            fetch_on_d = 1'b1;
                            flush = 1'b1;
                            cnt_d = '0;
                            state_d = cmd_q.has_mode ? ST_MODE : ST_DUMMY;
                            start_dummy = !cmd_q.has_mode;
                        end
                    end
                end
                ST_MODE: begin
                    if (samp) begin
                        cnt_n = cnt_q + 6'(cmd_q.aw);
                        mode_d = sh_n[7:0];
                        sh_d = sh_n;
                        cnt_d = cnt_n;
                        if (cnt_n == MODE_BITS) begin
                            mode_done_d = 1'b1;
                            state_d = ST_DUMMY;
                            start_dummy = 1'b1;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (fall) begin
                        if (dcnt_q == 4'h0) begin
                            emit = 1'b1;
                            state_d = ST_DATA;
                        end else begin
                            dcnt_d = dcnt_q - 1'b1;
                        end
                    end
                    if (cmd_q.ddr && learning_pattern_en &&
                        ((fall && dcnt_q != 4'h0 && dcnt_q <= PAT_CYCLES) ||
                         (rise && dcnt_q < PAT_CYCLES))) begin
                        io_o_d = {4{learning_pattern[pat_idx_q]}};
                        io_oe_d = 4'hF;
                        pat_idx_d = pat_idx_q - 1'b1;
                    end
                end
                ST_DATA: begin
                    emit = fall || (cmd_q.ddr && rise);
                end
                default: state_d = ST_IGNORE;
            endcase
        end
        if (start_dummy) begin
            dcnt_d = cmd_q.has_dummy ? latency_code : 4'h0;
            pat_idx_d = PAT_FIRST;
        end
        if (emit) begin
            pop = (ocnt_q == 4'h0);
            obyte_d = 8'(cur << cmd_q.ow);
            ocnt_d = 4'(((ocnt_q == 4'h0) ? BYTE_BITS : ocnt_q) - 4'(cmd_q.ow));
            unique case (cmd_q.ow)
                LANE_4: begin
                    io_o_d = cur[7:4];
                    io_oe_d = 4'hF;
                end
                LANE_2: begin
                    io_o_d = {2'b00, cur[7:6]};
                    io_oe_d = 4'h3;
                end
                default: begin
                    io_o_d = {2'b00, cur[7], 1'b0};
                    io_oe_d = 4'h2;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            cont_cmd_q <= '0;
            sh_q <= '0;
            cnt_q <= '0;
            mode_q <= '0;
            mode_done_q <= 1'b0;
            cont_q <= 1'b0;
            dcnt_q <= '0;
            pat_idx_q <= PAT_FIRST;
            obyte_q <= '0;
            ocnt_q <= '0;
            io_o_q <= '0;
            io_oe_q <= '0;
            fetch_on_q <= 1'b0;
            fetch_addr_q <= '0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            cont_cmd_q <= cont_cmd_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            mode_q <= mode_d;
            mode_done_q <= mode_done_d;
            cont_q <= cont_d;
            dcnt_q <= dcnt_d;
            pat_idx_q <= pat_idx_d;
            obyte_q <= obyte_d;
            ocnt_q <= ocnt_d;
            io_o_q <= io_o_d;
            io_oe_q <= io_oe_d;
            fetch_on_q <= fetch_on_d;
            fetch_addr_q <= fetch_addr_d;
        end
    end

    // ************************************************************
    // Outputs and FIFO hookup
    // ************************************************************
    assign buf_if.in_valid  = fetch_on_q;
    assign buf_if.in_data   = rd_data;
    assign buf_if.out_ready = pop;
    assign buf_if.flush     = flush;

    assign rd_en     = fetch_on_q && buf_if.in_ready && !flush;
    assign rd_addr   = fetch_addr_q;
    assign io_o      = io_o_q;
    assign io_oe     = io_oe_q;
    assign busy      = (state_q != ST_IDLE);
    assign cont_mode = cont_q;

endmodule

// file: sim/sfr_read_front_chk.sv
/* Assertion checker for the flash read front end, bound to its ports.
   Assumes one clock domain with an async active high reset. */
`timescale 1ns/1ps
module sfr_read_front_chk
    import sfr_pkg::*;
(
    input wire logic              clk,      // Clock
    input wire logic              rst,      // Reset
    input wire logic              sck,      // Link clock
    input wire logic              cs_n,     // Select
    input wire logic [3:0]        io_o,     // IO out
    input wire logic [3:0]        io_oe,    // IO enable
    input wire logic [ARR_AW-1:0] rd_addr,  // Array address
    input wire logic              rd_en,    // Byte taken
    input wire logic              busy,     // In frame
    input wire logic              cont_mode // Continuous
);
    logic [6:0] sck_h;
    logic [6:0] cs_h;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) {sck_h, cs_h} <= 14'h3FFF;
        else {sck_h, cs_h} <= {sck_h[5:0], sck, cs_h[5:0], cs_n};
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_end_quiet; cs_n [*6] |-> io_oe == 4'h0; endproperty
    a_end_quiet: assert property (p_end_quiet) else $error("drive after end");
    property p_end_idle; $rose(cs_n) |-> ##[1:6] !busy; endproperty
    a_end_idle: assert property (p_end_idle) else $error("busy after end");
    property p_start; $fell(cs_n) |-> ##[2:6] busy; endproperty
    a_start: assert property (p_start) else $error("no frame start");
    property p_op_quiet; $fell(cs_n) |-> ##4 (io_oe == 4'h0) [*8]; endproperty
    a_op_quiet: assert property (p_op_quiet) else $error("drive in opcode");
    property p_step; rd_en ##1 rd_en |-> rd_addr == $past(rd_addr) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("address step");
    property p_oe_frame; |io_oe |-> busy || $past(busy); endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("drive off frame");
    property p_fetch; rd_en |-> busy; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch off frame");
    property p_out_fall; $changed(io_o) |-> sck_h != 7'h7F || cs_h != 7'h00; endproperty
    a_out_fall: assert property (p_out_fall) else $error("io change off fall");
    property p_oe_fall; $rose(|io_oe) |-> sck_h != 7'h7F; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("drive start off fall");
    property p_cont; $changed(cont_mode) |-> !busy; endproperty
    a_cont: assert property (p_cont) else $error("mode flag mid frame");
    c_quad: cover property (io_oe == 4'hF);
    c_dual: cover property (io_oe == 4'h3);
    c_wrap: cover property (rd_en && rd_addr == '0);
    c_cont: cover property (cont_mode && busy);
endmodule
bind sfr_read_front sfr_read_front_chk u_chk (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .io_o(io_o), .io_oe(io_oe),
    .rd_addr(rd_addr), .rd_en(rd_en), .busy(busy), .cont_mode(cont_mode)
);

// file: sim/sfr_host_model.sv
/* Host controller model: drives link clock, select and IO lines.
   Assumes the bench resolves the shared IO wires. */
`timescale 1ns/1ps
module sfr_host_model (
    output logic            sck,   // Link clock
    output logic            cs_n,  // Select
    output logic      [3:0] h_io,  // Drive value
    output logic      [3:0] h_oe,  // Drive enable
    input  wire logic [3:0] io_w,  // Wire levels
    input  wire logic [3:0] io_oe  // Device enables
);
    logic [7:0] got [0:7];
    logic [3:0] oe_seen;
    initial begin
        sck = 1'b1;
        cs_n = 1'b1;
        h_io = 4'h0;
        h_oe = 4'h0;
    end
    task automatic tick(input logic [3:0] v, input logic [3:0] e, output logic [3:0] s);
        sck = 1'b0;
        h_io = v;
        h_oe = e;
        #160 sck = 1'b1;
        #150 s = io_w;
        oe_seen = oe_seen | io_oe;
        #10;
    endtask
    function automatic logic [3:0] lane(input logic [31:0] v, input int i, input int w);
        return (w == 4) ? 4'(v >> i) : {3'h0, v[i]};
    endfunction
    // Opcode lanes cl: 0 none (continuous), 1 or 4; md below zero: no mode byte
    task automatic xfer(input logic [7:0] op, input int ab, input logic [31:0] a,
                        input int dm, input int ln, input int nb, input int cl = 1,
                        input int md = -1);
        logic [3:0] s;
        logic [7:0] b;
        int         al;
        al = (cl == 4 || md >= 0) ? 4 : 1;
        oe_seen = 4'h0;
        cs_n = 1'b0;
        #160;
        for (int i = 8 - cl; cl > 0 && i >= 0; i -= cl) begin
            tick(lane(op, i, cl), lane(32'h0000_000F, 0, cl), s);
        end
        for (int i = ab * 8 - al; i >= 0; i -= al) begin
            tick(lane(a, i, al), lane(32'h0000_000F, 0, al), s);
        end
        for (int i = 4; md >= 0 && i >= 0; i -= 4) begin
            tick(lane(md, i, 4), 4'hF, s);
        end
        for (int i = 0; i < dm; i++) tick(4'h0, 4'h0, s);
        for (int n = 0; n < nb; n++) begin
            for (int k = 0; k < 8 / ln; k++) begin
                tick(4'h0, 4'h0, s);
                b = (ln == 1) ? {b[6:0], s[1]} : (ln == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
            end
            got[n] = b;
        end
        #40 cs_n = 1'b1;
        #400;
    endtask
endmodule

// file: sim/sfr_read_front_test.sv
/* Self-checking bench for the flash read front end.
   Assumes the host model drives the link; the array lives here. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module sfr_read_front_test
    import sfr_pkg::*;
;
    logic              clk, rst, alen, sck, cs_n, rd_en, busy, qpm, cont;
    logic [3:0]        lat, pat, h_io, h_oe, io_o, io_oe;
    wire  [3:0]        io_w;
    logic [ARR_AW-1:0] rd_addr;
    logic [7:0]        rd_data;
    int                errors, n_tests, cyc;
    function automatic logic [7:0] arr_byte(input logic [ARR_AW-1:0] a);
        return a[7:0] ^ a[22:15];
    endfunction
    assign rd_data = arr_byte(rd_addr);
    assign io_w = (io_oe & io_o) | (~io_oe & h_oe & h_io) | (~io_oe & ~h_oe & pat);
    sfr_read_front u_dut (
        .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .io_i(io_w), .io_o(io_o),
        .io_oe(io_oe), .addr_len_4b(alen), .latency_code(lat),
        .learning_pattern_en(1'b0), .learning_pattern(8'h00),
        .quad_peripheral_mode(qpm), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_en(rd_en), .busy(busy), .cont_mode(cont)
    );
    sfr_host_model u_host (
        .sck(sck), .cs_n(cs_n), .h_io(h_io), .h_oe(h_oe), .io_w(io_w), .io_oe(io_oe)
    );
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        pat <= ~pat;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic run_read(input logic [7:0] op, input logic [31:0] a, input logic a4,
                            input logic [3:0] lcode, input int ln, input int nb,
                            input int cl = 1, input int md = -1);
        logic [ARR_AW-1:0] ea;
        int ab;
        int dm;
        ab = (a4 || op inside {OP_READ_4B, OP_QUICK_4B, OP_DUAL_4B, OP_QUAD_4B}) ? 4 : 3;
        dm = (op inside {OP_READ, OP_READ_4B}) ? 0 : int'(lcode);
        @(posedge clk);
        #1;
        alen = a4;
        lat = lcode;
        qpm = (cl == 4);
        u_host.xfer(op, ab, a, dm, ln, nb, cl, md);
        ea = a[ARR_AW-1:0];
        for (int n = 0; n < nb; n++) begin
            `CHK("data", arr_byte(ea), u_host.got[n])
            ea = ea + 1'b1;
        end
        `CHK("lanes", (ln == 1) ? 4'h2 : (ln == 2) ? 4'h3 : 4'hF, u_host.oe_seen)
        `CHK("idle", 2'b00, {busy, |io_oe})
        `CHK("cont", (md >> 4) == 32'h0000_000A, cont)
    endtask
    task automatic t_single();
        run_read(OP_READ, 32'h0012_3456, 1'b0, 4'h5, 1, 3);
        run_read(OP_READ, 32'hFF7F_FFFE, 1'b1, 4'h5, 1, 4);
        run_read(OP_READ_4B, 32'hA500_0010, 1'b0, 4'h2, 1, 2);
        run_read(OP_QUICK, 32'h0000_00F0, 1'b0, 4'h2, 1, 2);
        run_read(OP_QUICK, 32'h0055_AA01, 1'b0, 4'h0, 1, 2);
        run_read(OP_QUICK_4B, 32'h017F_FFFF, 1'b0, 4'h3, 1, 2);
        $display("test single done");
    endtask
    task automatic t_dual();
        run_read(OP_DUAL, 32'h0000_0100, 1'b0, 4'h1, 2, 3);
        run_read(OP_DUAL, 32'h0A7F_FFFF, 1'b1, 4'h4, 2, 2);
        run_read(OP_DUAL_4B, 32'h0000_0200, 1'b0, 4'h0, 2, 2);
        $display("test dual done");
    endtask
    task automatic t_quad();
        run_read(OP_QUAD, 32'h0034_5678, 1'b0, 4'h3, 4, 4);
        run_read(OP_QUAD_4B, 32'h1200_0ABC, 1'b1, 4'h8, 4, 3);
        $display("test quad done");
    endtask
    task automatic t_cont();
        run_read(OP_READ, 32'h0000_0123, 1'b0, 4'h0, 4, 2, 4);
        run_read(OP_QIO, 32'h0000_1230, 1'b0, 4'h4, 4, 2, 1, 8'hA5);
        run_read(OP_QIO, 32'h0040_0005, 1'b0, 4'h4, 4, 2, 0, 8'h5F);
        $display("test cont done");
    endtask
    task automatic t_refuse();
        u_host.xfer(8'h5A, 3, 32'h0000_0000, 0, 1, 2);
        `CHK("refused", 4'h0, u_host.oe_seen)
        run_read(OP_READ, 32'h0000_0040, 1'b0, 4'h0, 1, 2);
        $display("test refuse done");
    endtask
    initial begin
        rst = 1'b1;
        {alen, qpm, lat, pat, errors, n_tests, cyc} = '0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (5) @(posedge clk);
        t_single();
        t_dual();
        t_quad();
        t_cont();
        t_refuse();
        print_verdict();
    end
endmodule
